// ### shared/ssc_pkg.sv
/*
 * constants and carrier types of the serial interface block
 * assumes one system clock; pins already synchronous to it
 */
package ssc_pkg;
    // register offsets in data space, and the bias removed for short io access
    localparam logic [7:0] ADDR_CTRL = 8'h4C;
    localparam logic [7:0] ADDR_STAT = 8'h4D;
    localparam logic [7:0] ADDR_DATA = 8'h4E;
    localparam logic [7:0] IO_BIAS = 8'h20;
    localparam logic [7:0] CTRL_RESET = 8'h00;
    localparam logic [7:0] STAT_RESET = 8'h00;
    localparam logic [7:0] DATA_RESET = 8'h00;
    // control field positions
    localparam int CTRL_IRQ_EN = 7;
    localparam int CTRL_EN = 6;
    localparam int CTRL_ORDER = 5;
    localparam int CTRL_MASTER = 4;
    localparam int CTRL_CPOL = 3;
    localparam int CTRL_CPHA = 2;
    localparam int CTRL_RATE_HI = 1;
    localparam int CTRL_RATE_LO = 0;
    // status field positions
    localparam int STAT_DONE = 7;
    localparam int STAT_WRITE_COLLISION_FLAG = 6;
    localparam int STAT_DOUBLE = 0;
    // sck half periods in system clocks, indexed by {double, rate}
    localparam logic [6:0] HALF_DIV4 = 7'h02;
    localparam logic [6:0] HALF_DIV16 = 7'h08;
    localparam logic [6:0] HALF_DIV64 = 7'h20;
    localparam logic [6:0] HALF_DIV128 = 7'h40;
    localparam logic [6:0] HALF_DIV2 = 7'h01;
    localparam logic [6:0] HALF_DIV8 = 7'h04;
    localparam logic [6:0] HALF_DIV32 = 7'h10;
    localparam logic [6:0] HALF_DIV64X = 7'h20;
    localparam logic [3:0] LAST_BIT = 4'h7;
    localparam logic [3:0] BYTE_BITS = 4'h8;

    typedef struct packed {
        logic sck;
        logic mosi;
        logic miso;
        logic ss;
    } ssc_pins_t;

    typedef enum logic [2:0] {
        ST_IDLE = 3'b001,
        ST_MASTER = 3'b010,
        ST_SLAVE = 3'b100
    } ssc_state_t;
endpackage

// ### hdl/ssc_prescaler.sv
/*
 * master sck prescaler: one-cycle tick every half sck period
 * assumes run falls as soon as the master transfer ends
 */
`timescale 1ns/100ps
module ssc_prescaler (
    input wire logic mclk_i,
    input wire logic reset_n_i,
    input wire logic run_i,
    input wire logic [2:0] rate_i,
    output logic tick_o
);
    logic [6:0] cnt;
    logic [6:0] half;
    wire last = (cnt == half - 7'h01);

    always_comb
    begin
        case (rate_i)
            3'b000: half = ssc_pkg::HALF_DIV4;
            3'b001: half = ssc_pkg::HALF_DIV16;
            3'b010: half = ssc_pkg::HALF_DIV64;
            3'b011: half = ssc_pkg::HALF_DIV128;
            3'b100: half = ssc_pkg::HALF_DIV2;
            3'b101: half = ssc_pkg::HALF_DIV8;
            3'b110: half = ssc_pkg::HALF_DIV32;
            default: half = ssc_pkg::HALF_DIV64X;
        endcase
    end

    always_ff @(posedge mclk_i or negedge reset_n_i)
    begin
        if (!reset_n_i)
        begin
            cnt <= 7'h00;
            tick_o <= 1'b0;
        end
        else
        begin
            cnt <= (!run_i || last) ? 7'h00 : cnt + 7'h01;
            tick_o <= run_i && last;
        end
    end

    property p_tick_gap;
        @(posedge mclk_i) disable iff (!reset_n_i)
        tick_o && rate_i == 3'b000 && run_i |=> !tick_o;
    endproperty
    a_tick_gap: assert property (p_tick_gap) else $error("sck tick faster than divide by four");
endmodule

// ### hdl/ssc_core.sv
/*
 * serial peripheral interface with slave select handling,
 * four data modes, bit order, master prescaler and status flags
 * assumes pins are synchronous to mclk_i; direction and port bits come from the port logic
 */
// Behaviour
// - slave, select low: active, miso per direction
// - slave, select high: passive, all pins input
// - select rising resets bit counter, drops partial
// - master, select output: plain port pin
// - select low in master: drop to slave
// - that drop sets done flag, may interrupt
// - drive and sample on opposite sck edges
// - four modes from polarity and phase
// - polarity sets sck idle level
// - phase picks leading or trailing sample
// - order bit one sends lsb first
// - nothing happens unless enable set
// - interrupt when enable, flag, global set
// - master bit selects master or slave
// - control at 0x4C, io offset minus 0x20
// - rate bits and double divide master sck
// - done flag set, cleared by vector or sequence
// - write during transfer sets collision flag
// - data write starts, read gives receive buffer
`timescale 1ns/100ps
module ssc_core (
    input wire logic mclk_i,
    input wire logic reset_n_i,
    input wire logic [7:0] addr_i,
    input wire logic io_space_i,
    input wire logic wr_i,
    input wire logic rd_i,
    input wire logic [7:0] wdata_i,
    output logic [7:0] rdata_o,
    input wire logic gie_i,
    input wire logic irq_ack_i,
    output logic irq_o,
    input wire ssc_pkg::ssc_pins_t pin_in_i,
    input wire ssc_pkg::ssc_pins_t pin_ddr_i,
    input wire ssc_pkg::ssc_pins_t pin_port_i,
    output ssc_pkg::ssc_pins_t pin_out_o,
    output ssc_pkg::ssc_pins_t pin_oe_n_o
);
    logic [7:0] ctrl;
    logic dbl;
    logic done_flag;
    logic write_collision_flag;
    logic armed;
    logic [7:0] rxbuf;
    logic [7:0] sh;
    logic out_bit;
    logic [3:0] cnt;
    logic sck_q;
    logic sck_prev;
    logic tick;
    ssc_pkg::ssc_state_t st;
    ssc_pkg::ssc_state_t next_st;

    // address decode, data space or short io space
    wire [7:0] base = io_space_i ? addr_i + ssc_pkg::IO_BIAS : addr_i;
    wire hit_ctrl = base == ssc_pkg::ADDR_CTRL;
    wire hit_stat = base == ssc_pkg::ADDR_STAT;
    wire hit_data = base == ssc_pkg::ADDR_DATA;
    wire wr_data = wr_i && hit_data;
    wire data_acc = (wr_i || rd_i) && hit_data;
    wire stat_rd = rd_i && hit_stat;

    wire en = ctrl[ssc_pkg::CTRL_EN];
    wire mst = ctrl[ssc_pkg::CTRL_MASTER];
    wire cpol = ctrl[ssc_pkg::CTRL_CPOL];
    wire cpha = ctrl[ssc_pkg::CTRL_CPHA];
    wire lsb = ctrl[ssc_pkg::CTRL_ORDER];
    wire in_master = st == ssc_pkg::ST_MASTER;
    wire in_slave = st == ssc_pkg::ST_SLAVE;

    wire mode_fault = en && mst && !pin_ddr_i.ss && !pin_in_i.ss;
    wire slave_sel = en && !mst && !pin_in_i.ss;
    wire busy = in_master || (in_slave && cnt != 4'h0);
    wire start_m = wr_data && !busy && en && mst && !mode_fault;

    // leading edge leaves the idle level, trailing edge returns to it
    wire m_lead = in_master && tick && (sck_q == cpol);
    wire m_trail = in_master && tick && (sck_q != cpol);
    wire s_lead = in_slave && (sck_prev == cpol) && (pin_in_i.sck != cpol);
    wire s_trail = in_slave && (sck_prev != cpol) && (pin_in_i.sck == cpol);
    wire lead = m_lead || s_lead;
    wire trail = m_trail || s_trail;
    wire sample_e = cpha ? trail : lead;
    wire setup_e = cpha ? lead : trail;
    wire rx_bit = in_master ? pin_in_i.miso : pin_in_i.mosi;
    wire head = lsb ? sh[0] : sh[7];
    wire w_head = lsb ? wdata_i[0] : wdata_i[7];
    wire [7:0] shifted = lsb ? {rx_bit, sh[7:1]} : {sh[6:0], rx_bit};
    wire done = sample_e && cnt == ssc_pkg::LAST_BIT;
    wire m_end = m_trail && ((sample_e && cnt == ssc_pkg::LAST_BIT) || cnt == ssc_pkg::BYTE_BITS);

    wire done_set = done || mode_fault;
    wire flag_clr = armed && data_acc;
    wire next_done = done_set || (done_flag && !(irq_ack_i || flag_clr));
    wire next_write_collision_flag = (wr_data && busy) || (write_collision_flag && !flag_clr);
    wire [7:0] stat_val = {done_flag, write_collision_flag, 5'h00, dbl};
    wire [7:0] next_rdata = !rd_i ? 8'h00 : hit_ctrl ? ctrl : hit_stat ? stat_val : hit_data ? rxbuf : 8'h00;

    // pin overrides while enabled, port control otherwise
    ssc_pkg::ssc_pins_t drv;
    ssc_pkg::ssc_pins_t val;
    assign drv.mosi = en ? mst && pin_ddr_i.mosi : pin_ddr_i.mosi;
    assign drv.sck = en ? mst && pin_ddr_i.sck : pin_ddr_i.sck;
    assign drv.miso = en ? !mst && pin_ddr_i.miso && !pin_in_i.ss : pin_ddr_i.miso;
    assign drv.ss = en ? mst && pin_ddr_i.ss : pin_ddr_i.ss;
    assign val.mosi = (en && mst) ? out_bit : pin_port_i.mosi;
    assign val.sck = (en && mst) ? sck_q : pin_port_i.sck;
    assign val.miso = (en && !mst) ? out_bit : pin_port_i.miso;
    assign val.ss = pin_port_i.ss;

    ssc_prescaler u_prescaler (
        .mclk_i(mclk_i),
        .reset_n_i(reset_n_i),
        .run_i(in_master && !m_end),
        .rate_i({dbl, ctrl[ssc_pkg::CTRL_RATE_HI], ctrl[ssc_pkg::CTRL_RATE_LO]}),
        .tick_o(tick)
    );

    always_comb
    begin
        next_st = st;
        case (st)
            ssc_pkg::ST_IDLE:
            begin
                if (start_m)
                    next_st = ssc_pkg::ST_MASTER;
                else if (slave_sel)
                    next_st = ssc_pkg::ST_SLAVE;
            end
            ssc_pkg::ST_MASTER:
            begin
                if (!en || !mst || mode_fault || m_end)
                    next_st = ssc_pkg::ST_IDLE;
            end
            ssc_pkg::ST_SLAVE:
            begin
                if (!slave_sel)
                    next_st = ssc_pkg::ST_IDLE;
            end
            default: next_st = ssc_pkg::ST_IDLE;
        endcase
    end

    always_ff @(posedge mclk_i or negedge reset_n_i)
    begin
        if (!reset_n_i)
        begin
            st <= ssc_pkg::ST_IDLE;
            ctrl <= ssc_pkg::CTRL_RESET;
            dbl <= 1'b0;
            done_flag <= 1'b0;
            write_collision_flag <= 1'b0;
            armed <= 1'b0;
            irq_o <= 1'b0;
            rdata_o <= 8'h00;
            sck_prev <= 1'b0;
        end
        else
        begin
            st <= next_st;
            if (mode_fault)
                ctrl <= ctrl & ~(8'h01 << ssc_pkg::CTRL_MASTER);
            else if (wr_i && hit_ctrl)
                ctrl <= wdata_i;
            if (wr_i && hit_stat)
                dbl <= wdata_i[ssc_pkg::STAT_DOUBLE];
            done_flag <= next_done;
            write_collision_flag <= next_write_collision_flag;
            armed <= stat_rd ? (done_flag || write_collision_flag) : (armed && !data_acc);
            irq_o <= ctrl[ssc_pkg::CTRL_IRQ_EN] && done_flag && gie_i;
            rdata_o <= next_rdata;
            sck_prev <= pin_in_i.sck;
        end
    end

    always_ff @(posedge mclk_i or negedge reset_n_i)
    begin
        if (!reset_n_i)
        begin
            sh <= ssc_pkg::DATA_RESET;
            rxbuf <= ssc_pkg::DATA_RESET;
            out_bit <= 1'b0;
            cnt <= 4'h0;
            sck_q <= 1'b0;
            pin_out_o <= '0;
            pin_oe_n_o <= '1;
        end
        else
        begin
            if (wr_data && !busy)
                sh <= wdata_i;
            else if (sample_e)
                sh <= shifted;
            if (done)
                rxbuf <= shifted;
            if (wr_data && !busy)
                out_bit <= w_head;
            else if (setup_e || (st == ssc_pkg::ST_IDLE && slave_sel))
                out_bit <= head;
            if (next_st == ssc_pkg::ST_IDLE)
                cnt <= 4'h0;
            else if (sample_e)
                cnt <= (in_slave && cnt == ssc_pkg::LAST_BIT) ? 4'h0 : cnt + 4'h1;
            sck_q <= in_master ? (tick ? !sck_q : sck_q) : cpol;
            pin_out_o <= val;
            pin_oe_n_o <= ~drv;
        end
    end

    default clocking @(posedge mclk_i);
    endclocking
    default disable iff (!reset_n_i);

    property p_fault;
        mode_fault |=> !mst && done_flag && st == ssc_pkg::ST_IDLE;
    endproperty
    a_fault: assert property (p_fault) else $error("select low did not demote master");
    property p_ss_rise;
        in_slave && pin_in_i.ss |=> cnt == 4'h0 && st == ssc_pkg::ST_IDLE;
    endproperty
    a_ss_rise: assert property (p_ss_rise) else $error("select rise did not reset slave");
    property p_passive;
        en && !mst && pin_in_i.ss |=> pin_oe_n_o.miso && pin_oe_n_o.mosi && pin_oe_n_o.sck;
    endproperty
    a_passive: assert property (p_passive) else $error("slave drove a pin while deselected");
    property p_idle_sck;
        st == ssc_pkg::ST_IDLE ##1 st == ssc_pkg::ST_IDLE |-> sck_q == $past(cpol);
    endproperty
    a_idle_sck: assert property (p_idle_sck) else $error("sck not at idle level");
    property p_disabled;
        !en |=> st == ssc_pkg::ST_IDLE && cnt == 4'h0;
    endproperty
    a_disabled: assert property (p_disabled) else $error("activity while disabled");
    property p_irq;
        ctrl[ssc_pkg::CTRL_IRQ_EN] && done_flag && gie_i |=> irq_o;
    endproperty
    a_irq: assert property (p_irq) else $error("interrupt not raised");
    property p_write_collision_flag;
        wr_data && busy |=> write_collision_flag;
    endproperty
    a_write_collision_flag: assert property (p_write_collision_flag) else $error("collision not flagged");
    property p_clear_seq;
        (stat_rd && done_flag && !done) ##1 (!stat_rd && !data_acc) ##1 (data_acc && !done_set) |=> !done_flag;
    endproperty
    a_clear_seq: assert property (p_clear_seq) else $error("flag not cleared by read sequence");
    property p_start;
        start_m |=> in_master && sh == $past(wdata_i);
    endproperty
    a_start: assert property (p_start) else $error("data write did not start master");
    property p_setup_only;
        in_master && !setup_e |=> $stable(out_bit);
    endproperty
    a_setup_only: assert property (p_setup_only) else $error("data changed off the setup edge");
    property p_lsb;
        sample_e && lsb && !(wr_data && !busy) |=> sh[7] == $past(rx_bit);
    endproperty
    a_lsb: assert property (p_lsb) else $error("lsb first shift wrong");
    property p_ss_out;
        en && mst && pin_ddr_i.ss |=> !pin_oe_n_o.ss && pin_out_o.ss == $past(pin_port_i.ss);
    endproperty
    a_ss_out: assert property (p_ss_out) else $error("select output not plain port");

    c_master_done: cover property (in_master && done);
    c_slave_done: cover property (in_slave && done);
    c_fault: cover property (mode_fault);
    c_write_collision_flag: cover property (wr_data && busy);
endmodule

// ### test/ssc_partner.sv
/*
 * behavioural external spi slave facing the block in master mode
 * assumes pins synchronous to mclk_i, mode bits shared with the bench
 */
`timescale 1ns/100ps
module ssc_partner (
    input wire logic mclk_i,
    input wire logic sck_i,
    input wire logic mosi_i,
    input wire logic cpol_i,
    input wire logic cpha_i,
    input wire logic lsb_i,
    input wire logic load_i,
    input wire logic [7:0] tx_i,
    output logic miso_o,
    output logic [7:0] rx_o
);
    logic sck_q;
    logic [3:0] idx;
    wire moved = sck_i != sck_q;
    wire lead = sck_i != cpol_i;
    wire sample = lead ^ cpha_i;

    function automatic logic bit_at(input logic [3:0] k);
        return lsb_i ? tx_i[k[2:0]] : tx_i[3'h7 - k[2:0]];
    endfunction

    initial miso_o = 1'b0;

    always @(posedge mclk_i)
    begin
        sck_q <= sck_i;
        if (load_i)
        begin
            idx <= {3'h0, !cpha_i};
            rx_o <= 8'h00;
            miso_o <= cpha_i ? ~miso_o : bit_at(4'h0);
        end
        else if (moved && sample)
            rx_o <= lsb_i ? {mosi_i, rx_o[7:1]} : {rx_o[6:0], mosi_i};
        else if (moved)
        begin
            // toggled after the eighth bit: no stale level
            miso_o <= idx < 4'h8 ? bit_at(idx) : ~miso_o;
            idx <= idx + 4'h1;
        end
    end
endmodule

// ### test/test_spi_select_mode_control.sv
/*
 * self-checking bench of the serial interface block
 * assumes the partner model answers as slave; bench plays master for slave tests
 */
`timescale 1ns/100ps
module test_spi_select_mode_control;
    logic mclk_i = 0, reset_n_i = 0, io = 0, wr = 0, rd = 0, gie = 0, ack = 0, ld = 0, irq, miso_m, sck_q;
    logic dbl_rate = 0;
    logic [7:0] addr = 0, wdata = 0, rdata, q, tx, pb, rx, ctl;
    logic [3:0] ddr = 0, port = 0, ext = 4'h1, pout, poe_n, pin_in;
    int seed = 32'h51af79bb, errors = 0, checks_done = 0, gap = 0, cnt = 0;

    assign pin_in = (poe_n & {ext[3:2], miso_m, ext[0]}) | (~poe_n & pout);

    ssc_core i_ssc_core (.mclk_i(mclk_i), .reset_n_i(reset_n_i), .addr_i(addr), .io_space_i(io),
        .wr_i(wr), .rd_i(rd), .wdata_i(wdata), .rdata_o(rdata), .gie_i(gie), .irq_ack_i(ack),
        .irq_o(irq), .pin_in_i(pin_in), .pin_ddr_i(ddr), .pin_port_i(port), .pin_out_o(pout),
        .pin_oe_n_o(poe_n));
    ssc_partner i_ssc_partner (.mclk_i(mclk_i), .sck_i(pin_in[3]), .mosi_i(pin_in[2]),
        .cpol_i(ctl[3]), .cpha_i(ctl[2]), .lsb_i(ctl[5]), .load_i(ld), .tx_i(pb), .miso_o(miso_m), .rx_o(rx));

    initial forever #10 mclk_i = ~mclk_i;

    // cycles between the last two sck changes
    always @(posedge mclk_i)
    begin
        sck_q <= pout[3];
        cnt <= (pout[3] !== sck_q) ? 1 : cnt + 1;
        if (pout[3] !== sck_q) gap <= cnt;
    end

    function automatic logic [7:0] half_of(input logic [2:0] r);
        case (r)
            3'h0: return {1'b0, ssc_pkg::HALF_DIV4};
            3'h1: return {1'b0, ssc_pkg::HALF_DIV16};
            3'h2: return {1'b0, ssc_pkg::HALF_DIV64};
            3'h3: return {1'b0, ssc_pkg::HALF_DIV128};
            3'h4: return {1'b0, ssc_pkg::HALF_DIV2};
            3'h5: return {1'b0, ssc_pkg::HALF_DIV8};
            3'h6: return {1'b0, ssc_pkg::HALF_DIV32};
            default: return {1'b0, ssc_pkg::HALF_DIV64X};
        endcase
    endfunction

    task report_and_stop;
        begin
            if (errors == 0 && checks_done > 0) $display("DONE - PASS");
            else $display("DONE - FAIL");
            $finish;
        end
    endtask

    task chk(input string n, input logic [7:0] s, input logic [7:0] e);
        begin
            checks_done++;
            if (s !== e)
            begin
                errors++;
                $display("[ERR] %s exp %h seen %h", n, e, s);
            end
        end
    endtask

    task acc(input logic w, input logic [7:0] a, input logic [7:0] d);
        begin
            @(posedge mclk_i);
            #1 io = 1'($random(seed));
            addr = io ? a - ssc_pkg::IO_BIAS : a;
            wr = w;
            rd = !w;
            wdata = d;
            @(posedge mclk_i);
            #1 wr = 0;
            rd = 0;
            q = rdata;
        end
    endtask

    task step(input int n);
        begin
            repeat (n) @(posedge mclk_i);
            #1;
        end
    endtask

    task wait_done;
        begin
            q = 0;
            repeat (2000) if (!q[7]) acc(0, ssc_pkg::ADDR_STAT, 0);
        end
    endtask

    task bang(input logic [7:0] b, input int n);
        begin
            for (int i = 0; i < n; i++)
            begin
                ext[2] = b[7 - i];
                step(4);
                ext[3] = 1;
                step(4);
                ext[3] = 0;
            end
        end
    endtask

    initial
    begin
        step(8);
        reset_n_i = 1;
        acc(0, ssc_pkg::ADDR_CTRL, 0);
        chk("ctrl reset", q, ssc_pkg::CTRL_RESET);
        ddr = 4'($random(seed));
        port = 4'($random(seed));
        acc(1, ssc_pkg::ADDR_DATA, 8'h3c);
        step(40);
        acc(0, ssc_pkg::ADDR_STAT, 0);
        chk("idle status", q, 8'h00);
        chk("idle oe", {4'h0, poe_n}, {4'h0, ~ddr});
        chk("idle out", {4'h0, pout}, {4'h0, port});
        for (int i = 0; i < 8; i++)
        begin
            ctl = 8'($random(seed));
            ctl[6] = 1;
            ctl[4] = 1;
            ctl[5] = i[2];
            ctl[3:2] = i[1:0];
            ctl[1:0] = 2'($unsigned($random(seed)) % 3 + 1);
            dbl_rate = 1'($random(seed));
            gie = 1'($random(seed));
            tx = 8'($random(seed));
            pb = 8'($random(seed));
            ddr = 4'hd;
            port = {3'h0, 1'($random(seed))};
            acc(1, ssc_pkg::ADDR_STAT, {7'h0, dbl_rate});
            acc(1, ssc_pkg::ADDR_CTRL, ctl);
            step(2);
            chk("sck idle", {7'h0, pout[3]}, {7'h0, ctl[3]});
            ld = 1;
            step(1);
            ld = 0;
            acc(1, ssc_pkg::ADDR_DATA, tx);
            acc(1, ssc_pkg::ADDR_DATA, ~tx);
            wait_done;
            chk("status", q, {7'h60, dbl_rate});
            step(1);
            chk("irq", {7'h0, irq}, {7'h0, ctl[7] & gie});
            chk("half", 8'(gap), half_of({dbl_rate, ctl[1:0]}));
            acc(0, ssc_pkg::ADDR_DATA, 0);
            chk("rx", q, pb);
            chk("mosi", rx, tx);
            acc(0, ssc_pkg::ADDR_STAT, 0);
            chk("cleared", q, {7'h0, dbl_rate});
            // let the last trailing sck edge pass before the next setup
            step(2 * int'(half_of({dbl_rate, ctl[1:0]})));
        end
        acc(1, ssc_pkg::ADDR_STAT, 0);
        ctl = 8'hd0;
        ddr = 4'hc;
        gie = 1;
        acc(1, ssc_pkg::ADDR_CTRL, ctl);
        ext[0] = 0;
        step(3);
        acc(0, ssc_pkg::ADDR_CTRL, 0);
        chk("fault ctrl", q, 8'hc0);
        chk("fault oe", {6'h0, poe_n[3:2]}, 8'h03);
        chk("fault irq", {7'h0, irq}, 8'h01);
        ack = 1;
        step(1);
        ack = 0;
        acc(0, ssc_pkg::ADDR_STAT, 0);
        chk("ack", q, 8'h00);
        ext[0] = 1;
        acc(1, ssc_pkg::ADDR_CTRL, ctl);
        acc(0, ssc_pkg::ADDR_CTRL, 0);
        chk("remaster", q, ctl);
        ctl = 8'h40;
        ddr = 4'h2;
        acc(1, ssc_pkg::ADDR_CTRL, ctl);
        bang(8'ha5, 8);
        acc(0, ssc_pkg::ADDR_STAT, 0);
        chk("ss high", q, 8'h00);
        chk("miso off", {7'h0, poe_n[1]}, 8'h01);
        ext[0] = 0;
        step(3);
        chk("miso on", {7'h0, poe_n[1]}, 8'h00);
        bang(8'hff, 3);
        ext[0] = 1;
        step(4);
        ext[0] = 0;
        bang(8'h96, 8);
        step(4);
        acc(0, ssc_pkg::ADDR_STAT, 0);
        chk("slave done", q, 8'h80);
        acc(0, ssc_pkg::ADDR_DATA, 0);
        chk("slave rx", q, 8'h96);
        report_and_stop;
    end

    initial
    begin
        step(60000);
        errors++;
        report_and_stop;
    end
endmodule
